//--- hdl/cfg_decode_pkg.sv
// Constants for the configuration register bank and base decoders
package cfg_decode_pkg;
	// Register indices
	localparam logic [7:0] IDX_TEST     = 8'h0F;
	localparam logic [7:0] IDX_CLKCTL   = 8'h10;
	localparam logic [7:0] IDX_IRTEST   = 8'h11;
	localparam logic [7:0] IDX_RSV_LO   = 8'h12;
	localparam logic [7:0] IDX_RSV_HI   = 8'h1D;
	localparam logic [7:0] IDX_GAME     = 8'h1E;
	localparam logic [7:0] IDX_DRVTYPE  = 8'h1F;
	localparam logic [7:0] IDX_FLOPPY   = 8'h20;
	localparam logic [7:0] IDX_IDECTL   = 8'h21;
	localparam logic [7:0] IDX_IDEALT   = 8'h22;
	// Reset values
	localparam logic [7:0] RST_TEST     = 8'h00;
	localparam logic [7:0] RST_CLKCTL   = 8'h00;
	localparam logic [7:0] RST_IRTEST   = 8'h00;
	localparam logic [7:0] RST_GAME     = 8'h80;
	localparam logic [7:0] RST_DRVTYPE  = 8'h00;
	localparam logic [7:0] RST_FLOPPY   = 8'h3C;
	localparam logic [7:0] RST_IDECTL   = 8'h3C;
	localparam logic [7:0] RST_IDEALT   = 8'h3D;
	// Writable masks
	localparam logic [7:0] MASK_CLKCTL  = 8'hF8;
	localparam logic [7:0] MASK_IRTEST  = 8'h03;
	localparam logic [7:0] MASK_BASE    = 8'hFC;
	// Fixed low bits
	localparam logic [1:0] LOW_BASE     = 2'h0;
	localparam logic [1:0] LOW_IDEALT   = 2'h1;
	localparam logic [3:0] ALT_LOW_ADDR = 4'h6;
	localparam logic [3:0] GAME_ONE_ADR = 4'h1;
	// Clock control bit positions
	localparam int POS_PLL_GAIN  = 3;
	localparam int POS_PLL_STOP  = 4;
	localparam int POS_UART_STOP = 5;
	localparam int POS_CLK_SEL   = 6;
	localparam int POS_IR_TEST   = 7;
	// Test control bit positions
	localparam int POS_IR_LOOP   = 0;
	localparam int POS_FLOPPY_TMO = 1;
	// Game decode modes
	typedef enum logic [1:0] {
		GAME_OFF  = 2'b00,
		GAME_ONE  = 2'b01,
		GAME_EIGHT = 2'b10,
		GAME_SIXTEEN = 2'b11
	} game_mode_t;
endpackage

//--- hdl/superio_config_decode_regs.sv
// Configuration register bank with game, floppy and IDE address decoders
// What this block does
// - registers reachable only in configuration mode with matching index value
// - clock control bits 0-2 and test control bits 2-7 read zero
// - clock control bit 3 selects normal or doubled multiplier loop gain
// - clock control bit 4 stops the frequency multiplying loops
// - uart clock stop gates 24MHz divider clock and holds dividers reset
// - clock control bit 6 selects 14.318MHz or 24MHz reference input
// - infrared test bit puts uart receive and transmit data on serial out
// - test control bit 0 loops infrared transmit back to receive
// - test control bit 1 enters floppy 10ms power-down timeout test
// - indices 12H through 1DH are reserved and hold zero
// - game base holds address bits 9-4, resets to 80H
// - game low bits pick disabled, one byte, eight or sixteen byte decode
// - game select needs chip select low, A10 low and a full match
// - power-good/game control bit 0 picks the shared pin function
// - two-bit drive type per drive steers the two density outputs
// - floppy base holds bits 9-4, low bits zero, resets 3CH, 9:8 zero disables
// - floppy select needs chip select low, A10 low, base match, 0XXXb
// - IDE control base holds bits 9-4, resets 3CH, 9:8 zero disables
// - IDE control select needs chip select low, A10 low, base match, 0XXXb
// - IDE alternate status base plus 6, low bits 0110b, resets 3DH
module superio_config_decode_regs
	import cfg_decode_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	// Register port
	input  wire logic       config_mode,
	input  wire logic [7:0] config_index_register,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Host address decode
	input  wire logic       chip_select_low,
	input  wire logic [10:0] host_addr,
	input  wire logic       power_good_game_control,
	output logic            game_chip_select,
	output logic            power_good_pin_mode,
	output logic            floppy_select,
	output logic            ide_control_select,
	output logic            ide_alt_status_select,
	// Clock generator controls and floppy timeout test
	output logic            pll_gain_double,
	output logic            pll_stop,
	output logic            pll_ref_24mhz,
	output logic            uart_div_clk_en,
	output logic            uart_div_reset,
	output logic            floppy_timeout_test,
	// Infrared and serial path
	input  wire logic       uart_rx_data,
	input  wire logic       uart_tx_data,
	input  wire logic       infrared_rx_in,
	output logic            infrared_rx_to_uart,
	input  wire logic       infrared_tx_out,
	output logic            serial_out_pin,
	// Floppy density
	input  wire logic [1:0] drive_select,
	input  wire logic       density_select,
	input  wire logic       rate_bit_0,
	input  wire logic       rate_bit_1,
	output logic            density_out_0,
	output logic            density_out_1
);
	typedef struct packed {
		logic [7:0] test_reserved_bits;
		logic [7:0] clock_generator_control;
		logic [7:0] infrared_and_timeout_test;
		logic [7:0] game_select_base;
		logic [7:0] drive_type_select;
		logic [7:0] floppy_base_address;
		logic [7:0] ide_control_base;
		logic [7:0] ide_alt_status_base;
		logic [7:0] rdata;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic       acc_ok;
	logic [7:0] rd_val;
	logic [1:0] dtype;
	logic       game_hit;
	logic       drive_a;
	logic       drive_b;
	logic       wr_hit;
	logic       rd_hit;

	assign acc_ok = config_mode;

	// Read value selected by index, reserved bits zero
	always_comb begin
		unique case (config_index_register)
			IDX_TEST:    rd_val = state_reg.test_reserved_bits;
			IDX_CLKCTL:  rd_val = state_reg.clock_generator_control & MASK_CLKCTL;
			IDX_IRTEST:  rd_val = state_reg.infrared_and_timeout_test & MASK_IRTEST;
			IDX_GAME:    rd_val = state_reg.game_select_base;
			IDX_DRVTYPE: rd_val = state_reg.drive_type_select;
			IDX_FLOPPY:  rd_val = state_reg.floppy_base_address;
			IDX_IDECTL:  rd_val = state_reg.ide_control_base;
			IDX_IDEALT:  rd_val = state_reg.ide_alt_status_base;
			default:     rd_val = 8'h00; // Reserved indices hold zero
		endcase
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = 8'h00;
		if (acc_ok && reg_rd) begin
			state_next.rdata = rd_val;
		end
		if (acc_ok && reg_wr) begin
			unique case (config_index_register)
				IDX_TEST:    state_next.test_reserved_bits = reg_wdata;
				IDX_CLKCTL:  state_next.clock_generator_control = reg_wdata & MASK_CLKCTL;
				IDX_IRTEST:  state_next.infrared_and_timeout_test = reg_wdata & MASK_IRTEST;
				IDX_GAME:    state_next.game_select_base = reg_wdata;
				IDX_DRVTYPE: state_next.drive_type_select = reg_wdata;
				IDX_FLOPPY:  state_next.floppy_base_address =
					{reg_wdata[7:2], LOW_BASE};
				IDX_IDECTL:  state_next.ide_control_base =
					{reg_wdata[7:2], LOW_BASE};
				IDX_IDEALT:  state_next.ide_alt_status_base =
					{reg_wdata[7:2], LOW_IDEALT};
				default:     state_next.rdata = state_next.rdata;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg.test_reserved_bits        <= RST_TEST;
			state_reg.clock_generator_control   <= RST_CLKCTL;
			state_reg.infrared_and_timeout_test <= RST_IRTEST;
			state_reg.game_select_base          <= RST_GAME;
			state_reg.drive_type_select         <= RST_DRVTYPE;
			state_reg.floppy_base_address       <= RST_FLOPPY;
			state_reg.ide_control_base          <= RST_IDECTL;
			state_reg.ide_alt_status_base       <= RST_IDEALT;
			state_reg.rdata                     <= 8'h00;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;

	// Clock generator controls and floppy timeout test
	assign pll_gain_double = state_reg.clock_generator_control[POS_PLL_GAIN];
	assign pll_stop        = state_reg.clock_generator_control[POS_PLL_STOP];
	assign uart_div_clk_en = !state_reg.clock_generator_control[POS_UART_STOP];
	assign uart_div_reset  = state_reg.clock_generator_control[POS_UART_STOP];
	assign pll_ref_24mhz   = state_reg.clock_generator_control[POS_CLK_SEL];
	assign floppy_timeout_test = state_reg.infrared_and_timeout_test[POS_FLOPPY_TMO];

	// Serial out carries the uart path data in test mode; rx and tx merged
	assign serial_out_pin = state_reg.clock_generator_control[POS_IR_TEST] ?
		(uart_rx_data & uart_tx_data) : uart_tx_data;
	assign infrared_rx_to_uart = state_reg.infrared_and_timeout_test[POS_IR_LOOP] ?
		infrared_tx_out : infrared_rx_in;

	// Game decode, combinational for same-cycle use
	always_comb begin
		unique case (game_mode_t'(state_reg.game_select_base[1:0]))
			GAME_OFF:     game_hit = 1'b0;
			GAME_ONE:     game_hit = (host_addr[3:0] == GAME_ONE_ADR);
			GAME_EIGHT:   game_hit = !host_addr[3];
			GAME_SIXTEEN: game_hit = 1'b1;
		endcase
	end

	assign game_chip_select = !power_good_game_control && !chip_select_low && !host_addr[10]
		&& (host_addr[9:4] == state_reg.game_select_base[7:2]) && game_hit;
	assign power_good_pin_mode = power_good_game_control;

	assign floppy_select = !chip_select_low && !host_addr[10]
		&& (state_reg.floppy_base_address[7:6] != 2'b00)
		&& (host_addr[9:4] == state_reg.floppy_base_address[7:2])
		&& !host_addr[3];
	assign ide_control_select = !chip_select_low && !host_addr[10]
		&& (state_reg.ide_control_base[7:6] != 2'b00)
		&& (host_addr[9:4] == state_reg.ide_control_base[7:2])
		&& !host_addr[3];
	assign ide_alt_status_select = !chip_select_low && !host_addr[10]
		&& (state_reg.ide_alt_status_base[7:6] != 2'b00)
		&& (host_addr[9:4] == state_reg.ide_alt_status_base[7:2])
		&& (host_addr[3:0] == ALT_LOW_ADDR);

	// Drive type: per drive, bit 2n+1 is type bit a, bit 2n is type bit b
	assign drive_a = state_reg.drive_type_select[{drive_select, 1'b1}];
	assign drive_b = state_reg.drive_type_select[{drive_select, 1'b0}];
	assign dtype   = {drive_a, drive_b};
	always_comb begin
		unique case (dtype)
			2'b00: begin
				density_out_0 = density_select;
				density_out_1 = rate_bit_0;
			end
			2'b01: begin
				density_out_0 = rate_bit_1;
				density_out_1 = rate_bit_0;
			end
			2'b10: begin
				density_out_0 = !density_select;
				density_out_1 = rate_bit_0;
			end
			2'b11: begin
				density_out_0 = rate_bit_0;
				density_out_1 = rate_bit_1;
			end
		endcase
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// Accepted strobes, as the register update sees them
	assign wr_hit = config_mode && reg_wr && clk_en;
	assign rd_hit = config_mode && reg_rd && clk_en;

	chk_wr_test: assert property (
		(wr_hit && config_index_register == IDX_TEST)
		|=> state_reg.test_reserved_bits == $past(reg_wdata))
		else $error("test register write lost");
	chk_wr_clkctl: assert property (
		(wr_hit && config_index_register == IDX_CLKCTL)
		|=> state_reg.clock_generator_control == ($past(reg_wdata) & MASK_CLKCTL))
		else $error("clock control write wrong");
	chk_wr_irtest: assert property (
		(wr_hit && config_index_register == IDX_IRTEST)
		|=> state_reg.infrared_and_timeout_test == ($past(reg_wdata) & MASK_IRTEST))
		else $error("test control write wrong");
	chk_wr_game: assert property (
		(wr_hit && config_index_register == IDX_GAME)
		|=> state_reg.game_select_base == $past(reg_wdata))
		else $error("game base write wrong");
	chk_wr_drvtype: assert property (
		(wr_hit && config_index_register == IDX_DRVTYPE)
		|=> state_reg.drive_type_select == $past(reg_wdata))
		else $error("drive type write wrong");
	chk_wr_floppy: assert property (
		(wr_hit && config_index_register == IDX_FLOPPY)
		|=> state_reg.floppy_base_address == {$past(reg_wdata[7:2]), LOW_BASE})
		else $error("floppy base write wrong");
	chk_wr_idectl: assert property (
		(wr_hit && config_index_register == IDX_IDECTL)
		|=> state_reg.ide_control_base == {$past(reg_wdata[7:2]), LOW_BASE})
		else $error("ide control base write wrong");
	chk_wr_idealt: assert property (
		(wr_hit && config_index_register == IDX_IDEALT)
		|=> state_reg.ide_alt_status_base == {$past(reg_wdata[7:2]), LOW_IDEALT})
		else $error("alt status base write wrong");
	chk_rd_test: assert property (
		(rd_hit && config_index_register == IDX_TEST)
		|=> reg_rdata == $past(state_reg.test_reserved_bits))
		else $error("test register read wrong");
	chk_rd_clkctl: assert property (
		(rd_hit && config_index_register == IDX_CLKCTL)
		|=> reg_rdata == ($past(state_reg.clock_generator_control) & MASK_CLKCTL))
		else $error("clock control read wrong");
	chk_rd_irtest: assert property (
		(rd_hit && config_index_register == IDX_IRTEST)
		|=> reg_rdata == ($past(state_reg.infrared_and_timeout_test) & MASK_IRTEST))
		else $error("test control read wrong");
	chk_rd_drvtype: assert property (
		(rd_hit && config_index_register == IDX_DRVTYPE)
		|=> reg_rdata == $past(state_reg.drive_type_select))
		else $error("drive type read wrong");
	chk_rd_floppy: assert property (
		(rd_hit && config_index_register == IDX_FLOPPY)
		|=> reg_rdata == $past(state_reg.floppy_base_address))
		else $error("floppy base read wrong");
	chk_rd_idectl: assert property (
		(rd_hit && config_index_register == IDX_IDECTL)
		|=> reg_rdata == $past(state_reg.ide_control_base))
		else $error("ide control base read wrong");
	chk_rd_idealt: assert property (
		(rd_hit && config_index_register == IDX_IDEALT)
		|=> reg_rdata == $past(state_reg.ide_alt_status_base))
		else $error("alt status base read wrong");
	chk_rd_reserved: assert property (
		(rd_hit && config_index_register >= IDX_RSV_LO && config_index_register <= IDX_RSV_HI)
		|=> reg_rdata == 8'h00)
		else $error("reserved index read not zero");
	chk_rd_idle: assert property (
		(clk_en && !rd_hit) |=> reg_rdata == 8'h00)
		else $error("read data without accepted read");
	chk_rd_hold: assert property (
		!clk_en |=> $stable(reg_rdata))
		else $error("read data moved while frozen");
	chk_freeze: assert property (
		!clk_en |=> $stable(state_reg))
		else $error("state moved while frozen");
	chk_game_pin: assert property (
		power_good_game_control |-> !game_chip_select)
		else $error("game select while pin is power-good");
	chk_game_off: assert property (
		state_reg.game_select_base[1:0] == 2'b00 |-> !game_chip_select)
		else $error("game decode not disabled");
	chk_serial_norm: assert property (
		!state_reg.clock_generator_control[POS_IR_TEST]
		|-> serial_out_pin == uart_tx_data)
		else $error("serial out wrong in normal mode");
	chk_ide_dis: assert property (
		state_reg.ide_control_base[7:6] == 2'b00 |-> !ide_control_select)
		else $error("ide control decode not disabled");
	chk_alt_dis: assert property (
		state_reg.ide_alt_status_base[7:6] == 2'b00 |-> !ide_alt_status_select)
		else $error("alt status decode not disabled");
	chk_ide_qual: assert property (
		(ide_control_select || ide_alt_status_select) |-> !chip_select_low && !host_addr[10])
		else $error("ide select unqualified");
	chk_floppy_qual: assert property (
		floppy_select |-> !chip_select_low && !host_addr[10] && !host_addr[3])
		else $error("floppy select unqualified");
	chk_alt_fixed: assert property (
		state_reg.ide_alt_status_base[1:0] == LOW_IDEALT)
		else $error("alt status low bits wrong");
	chk_no_cfg_write: assert property (
		(!config_mode && clk_en) |=> $stable(state_reg.clock_generator_control))
		else $error("register changed outside configuration mode");
	chk_rd_next: assert property (
		(config_mode && reg_rd && clk_en && config_index_register == IDX_GAME)
		|=> reg_rdata == $past(state_reg.game_select_base))
		else $error("read data wrong");
	chk_ro_zero: assert property (
		state_reg.clock_generator_control[2:0] == 3'h0
		&& state_reg.infrared_and_timeout_test[7:2] == 6'h00)
		else $error("read-only bits not zero");
	chk_uart_stop: assert property (
		uart_div_reset |-> !uart_div_clk_en)
		else $error("uart divider not held");
	chk_ir_loop: assert property (
		state_reg.infrared_and_timeout_test[0] |-> infrared_rx_to_uart == infrared_tx_out)
		else $error("infrared loopback wrong");
	chk_game_qual: assert property (
		game_chip_select |-> !chip_select_low && !host_addr[10])
		else $error("game select unqualified");
	chk_floppy_dis: assert property (
		state_reg.floppy_base_address[7:6] == 2'b00 |-> !floppy_select)
		else $error("floppy decode not disabled");
	chk_base_low: assert property (
		state_reg.floppy_base_address[1:0] == 2'b00
		&& state_reg.ide_control_base[1:0] == 2'b00)
		else $error("fixed low bits wrong");
	chk_alt_low: assert property (
		ide_alt_status_select |-> host_addr[3:0] == 4'h6)
		else $error("alt status decode wrong");

	cov_cfg_write: cover property (config_mode && reg_wr && clk_en);
	cov_game_hit: cover property (game_chip_select);
	cov_floppy_hit: cover property (floppy_select);
	cov_ide_hit: cover property (ide_control_select);
	cov_alt_hit: cover property (ide_alt_status_select);
endmodule

//--- verif/isa_host_model.sv
// Host processor model driving the configuration port and the address bus
module isa_host_model (
	// Clock
	input  wire logic  clk_sys,
	// Configuration port
	output logic       config_mode,
	output logic [7:0] config_index_register,
	output logic [7:0] reg_wdata,
	output logic       reg_wr,
	output logic       reg_rd,
	// Host address
	output logic       chip_select_low,
	output logic [10:0] host_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		config_mode = 1'b0;
		config_index_register = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		chip_select_low = 1'b1;
		host_addr = 11'h000;
	end
	// One-cycle strobe with index and data held beside it
	task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk_sys);
		config_index_register <= idx;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// Released data must not keep showing the last value
		reg_wdata <= ~d;
	endtask
	task automatic set_mode(input logic m);
		@(posedge clk_sys);
		config_mode <= m;
	endtask
	task automatic drive(input logic cs_n, input logic [10:0] a);
		@(posedge clk_sys);
		chip_select_low <= cs_n;
		host_addr <= a;
	endtask
endmodule

//--- verif/superio_config_decode_regs_tb.sv
// Self-checking bench for the configuration bank and its decoders
module superio_config_decode_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        clk_en = 1'b1;
	logic        pgc = 1'b0;
	logic [6:0]  misc = 7'h00;
	logic [1:0]  dsel = 2'h0;
	logic [7:0]  sh [8'h0F:8'h22];
	logic [7:0]  q [$];
	logic        rd_seen = 1'b0;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	integer      seed = 73;
	logic [31:0] r;
	logic        cm, csl, wr, rd, gcs, pgm, fs, ics, ias, pg2, ps, pr, uce, udr, ftt, irx, so, d0, d1;
	logic [7:0]  cx, wd, rdata, b;
	logic [10:0] ha;
	superio_config_decode_regs dut (.clk_sys, .nrst, .clk_en, .config_mode(cm),
		.config_index_register(cx), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.chip_select_low(csl), .host_addr(ha), .power_good_game_control(pgc),
		.game_chip_select(gcs), .power_good_pin_mode(pgm), .floppy_select(fs),
		.ide_control_select(ics), .ide_alt_status_select(ias), .pll_gain_double(pg2),
		.pll_stop(ps), .pll_ref_24mhz(pr), .uart_div_clk_en(uce), .uart_div_reset(udr),
		.floppy_timeout_test(ftt), .uart_rx_data(misc[6]), .uart_tx_data(misc[5]),
		.infrared_rx_in(misc[4]), .infrared_rx_to_uart(irx), .infrared_tx_out(misc[3]),
		.serial_out_pin(so), .drive_select(dsel), .density_select(misc[2]),
		.rate_bit_0(misc[1]), .rate_bit_1(misc[0]), .density_out_0(d0), .density_out_1(d1));
	isa_host_model host (.clk_sys, .config_mode(cm), .config_index_register(cx),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .chip_select_low(csl), .host_addr(ha));
	always #2.5 clk_sys = ~clk_sys;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp({7'h00, got}, {7'h00, exp});
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] msk(input logic [7:0] i);
		case (i)
			8'h0F, 8'h1E, 8'h1F: return 8'hFF;
			8'h10: return 8'hF8;
			8'h11: return 8'h03;
			8'h20, 8'h21, 8'h22: return 8'hFC;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic mapped(input logic [7:0] i);
		return cm && i >= 8'h0F && i <= 8'h22;
	endfunction
	task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
		host.access(1'b1, i, d);
		if (mapped(i)) begin
			sh[i] = (d & msk(i)) | ((i == 8'h22) ? 8'h01 : 8'h00);
		end
	endtask
	task automatic rd_reg(input logic [7:0] i);
		// Noted after the strobe, so a mode change just before is seen
		host.access(1'b0, i, 8'h00);
		q.push_back(mapped(i) ? sh[i] : 8'h00);
	endtask
	task automatic do_reset;
		nrst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		for (int i = 8'h0F; i <= 8'h22; i++) begin
			sh[i] = 8'h00;
		end
		sh[8'h1E] = 8'h80;
		sh[8'h20] = 8'h3C;
		sh[8'h21] = 8'h3C;
		sh[8'h22] = 8'h3D;
	endtask
	task automatic rd_all;
		for (int i = 8'h0E; i <= 8'h23; i++) begin
			rd_reg(8'(i));
		end
	endtask
	task automatic check_all;
		logic [1:0] ty;
		logic       ok;
		ty = {sh[8'h1F][{dsel, 1'b1}], sh[8'h1F][{dsel, 1'b0}]};
		ok = !csl && !ha[10];
		cmp_bit(gcs, ok && !pgc && ha[9:4] == sh[8'h1E][7:2] && (sh[8'h1E][1:0] == 2'b11 ||
			(sh[8'h1E][1:0] == 2'b10 && !ha[3]) ||
			(sh[8'h1E][1:0] == 2'b01 && ha[3:0] == 4'h1)));
		cmp_bit(pgm, pgc);
		cmp_bit(fs, ok && ha[9:4] == sh[8'h20][7:2] && !ha[3] && sh[8'h20][7:6] != 2'b00);
		cmp_bit(ics, ok && ha[9:4] == sh[8'h21][7:2] && !ha[3] && sh[8'h21][7:6] != 2'b00);
		cmp_bit(ias, ok && ha[9:4] == sh[8'h22][7:2] && ha[3:0] == 4'h6 &&
			sh[8'h22][7:6] != 2'b00);
		cmp_bit(pg2, sh[8'h10][3]);
		cmp_bit(ps, sh[8'h10][4]);
		cmp_bit(uce, !sh[8'h10][5]);
		cmp_bit(udr, sh[8'h10][5]);
		cmp_bit(pr, sh[8'h10][6]);
		cmp_bit(so, sh[8'h10][7] ? misc[6] & misc[5] : misc[5]);
		cmp_bit(irx, sh[8'h11][0] ? misc[3] : misc[4]);
		cmp_bit(ftt, sh[8'h11][1]);
		cmp_bit(d0, ty == 2'b00 ? misc[2] : ty == 2'b01 ? misc[0] :
			ty == 2'b10 ? !misc[2] : misc[1]);
		cmp_bit(d1, (ty == 2'b11) ? misc[0] : misc[1]);
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		rd_seen <= rd & clk_en;
		if (rd_seen) begin
			cmp(rdata, q.pop_front());
		end
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		do_reset();
		host.set_mode(1'b1);
		rd_all();
		$display("test reset_values done");
		for (int p = 0; p < 2; p++) begin
			wr_reg(8'h0F, 8'h00);
			for (int i = 8'h10; i <= 8'h23; i++) begin
				wr_reg(8'(i), 8'($random(seed)));
			end
			rd_all();
		end
		$display("test write_read done");
		host.set_mode(1'b0);
		wr_reg(8'h1F, ~sh[8'h1F]);
		rd_reg(8'h1F);
		host.set_mode(1'b1);
		rd_reg(8'h1F);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		host.access(1'b1, 8'h1F, ~sh[8'h1F]);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		rd_reg(8'h1F);
		$display("test mode_gate done");
		for (int m = 0; m < 16; m++) begin
			for (int i = 8'h10; i <= 8'h22; i++) begin
				wr_reg(8'(i), 8'($random(seed)));
			end
			for (int k = 0; k < 16; k++) begin
				r = $random(seed);
				b = (r[1:0] == 2'b00) ? sh[8'h1E] : sh[8'h1F + 8'(r[1:0])];
				host.drive(r[9] & r[10], {r[3] & r[4], b[7:2], r[8:5]});
				misc <= r[17:11];
				dsel <= r[19:18];
				pgc <= r[20];
				@(negedge clk_sys);
				check_all();
			end
		end
		$display("test decode_outputs done");
		do_reset();
		rd_all();
		@(negedge clk_sys);
		check_all();
		$display("test second_reset done");
		final_report();
	end
endmodule
